// ### pkg/pllcfg_defines.svh
// Constants of the PLL divider register bank: offsets, masks, resets, field positions
`ifndef PLLCFG_DEFINES_SVH
`define PLLCFG_DEFINES_SVH
// ----------------------------------------------------------------
// Register count and byte offsets on the register port
// ----------------------------------------------------------------
`define PLLCFG_NREG 10
`define PLLCFG_A_FB_PH 4'h0
`define PLLCFG_A_FB_LO 4'h1
`define PLLCFG_A_S_LO 4'h2
`define PLLCFG_A_S_MSB 4'h3
`define PLLCFG_A_REF_PH 4'h4
`define PLLCFG_A_REF_LO 4'h5
`define PLLCFG_A_SY_MSB 4'h8
`define PLLCFG_A_SY_LO 4'h9
`define PLLCFG_A_BYP 4'ha
`define PLLCFG_A_DBL 4'hc
// ----------------------------------------------------------------
// Storage index of each register
// ----------------------------------------------------------------
`define PLLCFG_I_FB_PH 0
`define PLLCFG_I_FB_LO 1
`define PLLCFG_I_S_LO 2
`define PLLCFG_I_S_MSB 3
`define PLLCFG_I_REF_PH 4
`define PLLCFG_I_REF_LO 5
`define PLLCFG_I_SY_MSB 6
`define PLLCFG_I_SY_LO 7
`define PLLCFG_I_BYP 8
`define PLLCFG_I_DBL 9
// ----------------------------------------------------------------
// Writable-bit masks (reserved bits are zero) and reset values
// ----------------------------------------------------------------
`define PLLCFG_MASKS '{8'hff, 8'hff, 8'hff, 8'h81, 8'hef, 8'hff, 8'h01, 8'hff, 8'h01, 8'hbf}
`define PLLCFG_RESETS '{8'h0c, 8'h00, 8'h60, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00}
// ----------------------------------------------------------------
// Field positions and divider limits
// ----------------------------------------------------------------
`define PLLCFG_PH_HI 7
`define PLLCFG_PH_LO 5
`define PLLCFG_PD_BIT 4
`define PLLCFG_UP_HI 3
`define PLLCFG_MSB_BIT 7
`define PLLCFG_LSB_BIT 0
`define PLLCFG_PF_HI 5
`define PLLCFG_RSV_HI 6
`define PLLCFG_RSV_LO 1
`define PLLCFG_FIRST_W 12
`define PLLCFG_SECOND_W 9
`define PLLCFG_FIRST_MIN 12'h001
`define PLLCFG_SECOND_MIN 9'h004
`define PLLCFG_WIN_W 4
`endif

// ### pkg/pllcfg_pkg.sv
// Types shared by the PLL divider register bank
`default_nettype none
package pllcfg_pkg;
    // Register port request, one cycle per access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } pllcfg_req_t;

    // All configuration fields as seen by the PLL
    typedef struct packed {
        logic [2:0] fb_div_phase_sel;
        logic second_fb_div_powerdown;
        logic [11:0] first_fb_div_value;
        logic [8:0] second_fb_div_value;
        logic fb_cascade_sel;
        logic [2:0] ref_div_phase_sel;
        logic [11:0] ref_div_value;
        logic [8:0] synth_fb_div_value;
        logic first_pll_bypass;
        logic freq_doubler_sel;
        logic [5:0] synth_prediv_value;
    } pllcfg_cfg_t;

    // Lock-detect sampling sequencer
    typedef enum logic [1:0] {
        LW_IDLE = 2'b00,
        LW_DELAY = 2'b01,
        LW_OPEN = 2'b10
    } pllcfg_lw_state_t;
endpackage
`default_nettype wire

// ### hdl/pllcfg_div.sv
// Programmable pulse divider used for both feedback dividers
`include "pllcfg_defines.svh"
`default_nettype none
module pllcfg_div #(
    parameter int WIDTH = `PLLCFG_FIRST_W,
    parameter logic [WIDTH-1:0] MIN = `PLLCFG_FIRST_MIN
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic in_tick,
    input wire logic [WIDTH-1:0] ratio,
    output logic out_tick
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic out_nxt;
    logic [WIDTH-1:0] eff;
    logic [WIDTH-1:0] term;

    // Ratios below the legal floor are clamped so the counter never wraps
    assign eff = (ratio < MIN) ? MIN : ratio;
    assign term = eff - WIDTH'(1);

    // Next count; >= lets a lowered ratio take effect at once
    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = 1'b0;
        if (!en) begin
            cnt_nxt = '0; // RULE7
        end else if (in_tick) begin
            if (cnt_r >= term) begin
                cnt_nxt = '0;
                out_nxt = 1'b1; // RULE4 RULE5
            end else begin
                cnt_nxt = cnt_r + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            out_tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_tick <= out_nxt;
        end
    end

    property p_div_term;
        @(posedge clk) disable iff (!rst_n)
        out_tick |-> $past(in_tick) && $past(en) && ($past(cnt_r) >= $past(term));
    endproperty
    a_div_term: assert property (p_div_term) else $error("divider pulse without terminal count"); // RULE4

    property p_div_step;
        @(posedge clk) disable iff (!rst_n)
        en && in_tick && (cnt_r < term) |=> !out_tick && (cnt_r == $past(cnt_r) + WIDTH'(1));
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider count did not advance"); // RULE5

    property p_div_off;
        @(posedge clk) disable iff (!rst_n)
        !en ##1 !en |-> (cnt_r == '0) && !out_tick;
    endproperty
    a_div_off: assert property (p_div_off) else $error("disabled divider still running"); // RULE7
endmodule
`default_nettype wire

// ### hdl/pllcfg_lockwin.sv
// Lock-detect sampling phase and window sequencer
`include "pllcfg_defines.svh"
`default_nettype none
module pllcfg_lockwin (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pd_edge,
    input wire logic fb_edge,
    input wire logic [2:0] fb_phase,
    input wire logic [2:0] ref_phase,
    output logic sample,
    output logic in_window
);
    import pllcfg_pkg::*;

    pllcfg_lw_state_t st_r;
    pllcfg_lw_state_t st_nxt;
    logic [`PLLCFG_WIN_W-1:0] cnt_r;
    logic [`PLLCFG_WIN_W-1:0] cnt_nxt;
    logic hit_r;
    logic hit_nxt;
    logic smp_nxt;
    logic win_nxt;

    // Delay after the detector edge, then an open window; edges during a run are ignored
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        hit_nxt = hit_r;
        smp_nxt = 1'b0;
        win_nxt = in_window;
        unique case (st_r)
            LW_IDLE: begin
                if (pd_edge) begin
                    st_nxt = LW_DELAY;
                    cnt_nxt = {1'b0, fb_phase}; // RULE3
                end
            end
            LW_DELAY: begin
                if (cnt_r == '0) begin
                    smp_nxt = 1'b1; // RULE3
                    st_nxt = LW_OPEN;
                    cnt_nxt = {1'b0, fb_phase} + {1'b0, ref_phase}; // RULE2
                    hit_nxt = fb_edge;
                end else begin
                    cnt_nxt = cnt_r - `PLLCFG_WIN_W'(1);
                end
            end
            LW_OPEN: begin
                if (fb_edge) begin
                    hit_nxt = 1'b1;
                end
                if (cnt_r == '0) begin
                    win_nxt = hit_r | fb_edge; // RULE2
                    st_nxt = LW_IDLE;
                end else begin
                    cnt_nxt = cnt_r - `PLLCFG_WIN_W'(1);
                end
            end
            default: begin
                st_nxt = LW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LW_IDLE;
            cnt_r <= '0;
            hit_r <= 1'b0;
            sample <= 1'b0;
            in_window <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            hit_r <= hit_nxt;
            sample <= smp_nxt;
            in_window <= win_nxt;
        end
    end

    property p_lw_start;
        @(posedge clk) disable iff (!rst_n)
        (st_r == LW_IDLE) && pd_edge |=> (st_r == LW_DELAY) && (cnt_r == {1'b0, $past(fb_phase)});
    endproperty
    a_lw_start: assert property (p_lw_start) else $error("sampling delay not loaded from phase select"); // RULE3

    property p_lw_sample;
        @(posedge clk) disable iff (!rst_n)
        sample |-> ($past(st_r) == LW_DELAY) && ($past(cnt_r) == '0);
    endproperty
    a_lw_sample: assert property (p_lw_sample) else $error("sample strobe at wrong time"); // RULE3

    property p_lw_window;
        @(posedge clk) disable iff (!rst_n)
        (st_r == LW_DELAY) && (cnt_r == '0)
            |=> (st_r == LW_OPEN) && (cnt_r == {1'b0, $past(fb_phase)} + {1'b0, $past(ref_phase)});
    endproperty
    a_lw_window: assert property (p_lw_window) else $error("window length not set by both phase selects"); // RULE2
endmodule
`default_nettype wire

// ### hdl/pllcfg_regs.sv
// PLL feedback-divider configuration registers with divider and lock-window logic
//
// Contract
// RULE1 - Software sets feedback phase select to suit the first feedback divider value.
// RULE2 - Lock-detect window comes from both feedback and reference phase selects, reset zero.
// RULE3 - Sampling phase from feedback phase select is timed from the detector edge.
// RULE4 - First feedback divider takes twelve bits, divides 1 to 4095, resets to 3072.
// RULE5 - Second feedback divider takes nine bits, divides 4 to 511, resets to 96.
// RULE6 - Fields sit at offsets 0 to 3 in the documented bit positions.
// RULE7 - Second divider power-down bit 0 runs it, 1 stops and disables it.
// RULE8 - Cascade bit 0 feeds back first divider only, 1 uses both in series.
// RULE9 - Reserved bits ignore writes and read back as zero.
`include "pllcfg_defines.svh"
`default_nettype none
module pllcfg_regs (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire pllcfg_pkg::pllcfg_req_t CFG_REQ,
    input wire logic FB_IN_TICK,
    input wire logic PD_EDGE,
    output logic [7:0] CFG_RDATA,
    output logic CFG_RVALID,
    output pllcfg_pkg::pllcfg_cfg_t PLL_CFG,
    output logic FB_DIV_OUT,
    output logic LOCK_SAMPLE,
    output logic LOCK_IN_WINDOW
);
    import pllcfg_pkg::*;

    // ------------------------------------------------------------
    // Register table
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR [`PLLCFG_NREG] = '{
        `PLLCFG_A_FB_PH, `PLLCFG_A_FB_LO, `PLLCFG_A_S_LO,
        `PLLCFG_A_S_MSB, `PLLCFG_A_REF_PH, `PLLCFG_A_REF_LO,
        `PLLCFG_A_SY_MSB, `PLLCFG_A_SY_LO, `PLLCFG_A_BYP,
        `PLLCFG_A_DBL};
    localparam logic [7:0] MASK [`PLLCFG_NREG] = `PLLCFG_MASKS;
    localparam logic [7:0] RSTV [`PLLCFG_NREG] = `PLLCFG_RESETS;

    logic [7:0] regs [`PLLCFG_NREG];
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;
    logic fb_nxt;
    logic first_tick;
    logic second_tick;

    // ------------------------------------------------------------
    // Storage, one slot per register
    // ------------------------------------------------------------
    genvar g;
    for (g = 0; g < `PLLCFG_NREG; g++) begin : g_reg
        logic [7:0] val_r;
        logic [7:0] val_nxt;

        // Masking at write time keeps reserved bits zero in storage
        always_comb begin
            val_nxt = val_r;
            if (CFG_REQ.wr && (CFG_REQ.addr == ADDR[g])) begin
                val_nxt = CFG_REQ.wdata & MASK[g]; // RULE6 RULE9
            end
        end

        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                val_r <= RSTV[g]; // RULE4 RULE5 RULE2
            end else begin
                val_r <= val_nxt;
            end
        end

        assign regs[g] = val_r;
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Registered read data; an unmapped offset answers zero
    always_comb begin
        rvalid_nxt = CFG_REQ.rd;
        rdata_nxt = CFG_RDATA;
        if (CFG_REQ.rd) begin
            rdata_nxt = 8'h00;
            for (int i = 0; i < `PLLCFG_NREG; i++) begin
                if (CFG_REQ.addr == ADDR[i]) begin
                    rdata_nxt = regs[i]; // RULE9
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CFG_RDATA <= 8'h00;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RDATA <= rdata_nxt;
            CFG_RVALID <= rvalid_nxt;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // Pure wiring from storage, so every field is a flip-flop output
    always_comb begin
        PLL_CFG.fb_div_phase_sel = regs[`PLLCFG_I_FB_PH][`PLLCFG_PH_HI:`PLLCFG_PH_LO]; // RULE6
        PLL_CFG.second_fb_div_powerdown = regs[`PLLCFG_I_FB_PH][`PLLCFG_PD_BIT];
        PLL_CFG.first_fb_div_value = {regs[`PLLCFG_I_FB_PH][`PLLCFG_UP_HI:0],
            regs[`PLLCFG_I_FB_LO]}; // RULE4
        PLL_CFG.second_fb_div_value = {regs[`PLLCFG_I_S_MSB][`PLLCFG_MSB_BIT],
            regs[`PLLCFG_I_S_LO]}; // RULE5
        PLL_CFG.fb_cascade_sel = regs[`PLLCFG_I_S_MSB][`PLLCFG_LSB_BIT];
        PLL_CFG.ref_div_phase_sel = regs[`PLLCFG_I_REF_PH][`PLLCFG_PH_HI:`PLLCFG_PH_LO]; // RULE2
        PLL_CFG.ref_div_value = {regs[`PLLCFG_I_REF_PH][`PLLCFG_UP_HI:0],
            regs[`PLLCFG_I_REF_LO]};
        PLL_CFG.synth_fb_div_value = {regs[`PLLCFG_I_SY_MSB][`PLLCFG_LSB_BIT],
            regs[`PLLCFG_I_SY_LO]};
        PLL_CFG.first_pll_bypass = regs[`PLLCFG_I_BYP][`PLLCFG_LSB_BIT];
        PLL_CFG.freq_doubler_sel = regs[`PLLCFG_I_DBL][`PLLCFG_MSB_BIT];
        PLL_CFG.synth_prediv_value = regs[`PLLCFG_I_DBL][`PLLCFG_PF_HI:0];
    end

    // ------------------------------------------------------------
    // Feedback dividers
    // ------------------------------------------------------------
    // First divider always runs; it sets the basic feedback ratio
    pllcfg_div #(
        .WIDTH(`PLLCFG_FIRST_W),
        .MIN(`PLLCFG_FIRST_MIN)
    ) u_first (
        .clk(CLK),
        .rst_n(RESET_N),
        .en(1'b1),
        .in_tick(FB_IN_TICK),
        .ratio(PLL_CFG.first_fb_div_value), // RULE4
        .out_tick(first_tick)
    );

    // Second divider chains on the first; power-down holds its count at zero to save power
    pllcfg_div #(
        .WIDTH(`PLLCFG_SECOND_W),
        .MIN(`PLLCFG_SECOND_MIN)
    ) u_second (
        .clk(CLK),
        .rst_n(RESET_N),
        .en(!PLL_CFG.second_fb_div_powerdown), // RULE7
        .in_tick(first_tick),
        .ratio(PLL_CFG.second_fb_div_value), // RULE5
        .out_tick(second_tick)
    );

    // Cascade choice; with the second divider powered down a cascaded path goes silent
    always_comb begin
        fb_nxt = PLL_CFG.fb_cascade_sel ? second_tick : first_tick; // RULE8
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FB_DIV_OUT <= 1'b0;
        end else begin
            FB_DIV_OUT <= fb_nxt;
        end
    end

    // ------------------------------------------------------------
    // Lock-detect window
    // ------------------------------------------------------------
    // Software must pick the phase select to match the divider range
    pllcfg_lockwin u_lockwin (
        .clk(CLK),
        .rst_n(RESET_N),
        .pd_edge(PD_EDGE),
        .fb_edge(FB_DIV_OUT),
        .fb_phase(PLL_CFG.fb_div_phase_sel), // RULE1 RULE3
        .ref_phase(PLL_CFG.ref_div_phase_sel), // RULE2
        .sample(LOCK_SAMPLE),
        .in_window(LOCK_IN_WINDOW)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_vals;
        @(posedge CLK) disable iff (!RESET_N)
        $rose(RESET_N) |-> (PLL_CFG.first_fb_div_value == {RSTV[`PLLCFG_I_FB_PH][`PLLCFG_UP_HI:0],
            RSTV[`PLLCFG_I_FB_LO]}) && (PLL_CFG.second_fb_div_value == {1'b0, RSTV[`PLLCFG_I_S_LO]})
            && (PLL_CFG.fb_div_phase_sel == 3'h0) && (PLL_CFG.ref_div_phase_sel == 3'h0);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("divider reset values wrong"); // RULE4

    property p_wr_fb_ph;
        @(posedge CLK) disable iff (!RESET_N)
        CFG_REQ.wr && (CFG_REQ.addr == `PLLCFG_A_FB_PH)
            |=> (PLL_CFG.fb_div_phase_sel == $past(CFG_REQ.wdata[7:5]))
            && (PLL_CFG.second_fb_div_powerdown == $past(CFG_REQ.wdata[4]))
            && (PLL_CFG.first_fb_div_value[11:8] == $past(CFG_REQ.wdata[3:0]));
    endproperty
    a_wr_fb_ph: assert property (p_wr_fb_ph) else $error("offset 0 fields misplaced"); // RULE6

    property p_wr_s_msb;
        @(posedge CLK) disable iff (!RESET_N)
        CFG_REQ.wr && (CFG_REQ.addr == `PLLCFG_A_S_MSB)
            |=> (PLL_CFG.second_fb_div_value[8] == $past(CFG_REQ.wdata[7]))
            && (PLL_CFG.fb_cascade_sel == $past(CFG_REQ.wdata[0]));
    endproperty
    a_wr_s_msb: assert property (p_wr_s_msb) else $error("offset 3 fields misplaced"); // RULE5

    property p_rsv_zero;
        @(posedge CLK) disable iff (!RESET_N)
        CFG_REQ.rd && !CFG_REQ.wr && (CFG_REQ.addr == `PLLCFG_A_S_MSB)
            |=> CFG_RVALID && (CFG_RDATA[`PLLCFG_RSV_HI:`PLLCFG_RSV_LO] == 6'h00);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero"); // RULE9

    property p_casc_off;
        @(posedge CLK) disable iff (!RESET_N)
        !PLL_CFG.fb_cascade_sel |-> (first_tick ##1 FB_DIV_OUT) or (!first_tick ##1 !FB_DIV_OUT);
    endproperty
    a_casc_off: assert property (p_casc_off) else $error("direct feedback path wrong"); // RULE8

    property p_casc_on;
        @(posedge CLK) disable iff (!RESET_N)
        PLL_CFG.fb_cascade_sel && !second_tick |=> !FB_DIV_OUT;
    endproperty
    a_casc_on: assert property (p_casc_on) else $error("cascaded path pulsed without second divider"); // RULE8

    property p_pd_quiet;
        @(posedge CLK) disable iff (!RESET_N)
        PLL_CFG.second_fb_div_powerdown [*2] |-> !second_tick;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("powered-down divider pulsed"); // RULE7

    property p_win_len;
        @(posedge CLK) disable iff (!RESET_N)
        LOCK_SAMPLE && (PLL_CFG.fb_div_phase_sel == 3'h0) && (PLL_CFG.ref_div_phase_sel == 3'h0)
            && $stable(PLL_CFG.fb_div_phase_sel) ##1 !PD_EDGE |-> ##1 !LOCK_SAMPLE;
    endproperty
    a_win_len: assert property (p_win_len) else $error("second sample inside shortest window"); // RULE2
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the PLL feedback-divider register bank
`include "pllcfg_defines.svh"
`default_nettype none
// ----------------------------------------------------------------
// Shared comparison: counts every check, reports a mismatch at once
// ----------------------------------------------------------------
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pllcfg_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    pllcfg_req_t cfg_req = '0;
    logic fb_tick = 1'b0;
    logic pd_edge = 1'b0;
    logic [7:0] cfg_rdata;
    logic cfg_rvalid;
    pllcfg_cfg_t pll_cfg;
    logic fb_div_out;
    logic lock_sample;
    logic lock_in_window;
    int failures = 0;
    int comparisons = 0;
    int pulses = 0;
    int seed = 32'ha9e636f7;
    logic [7:0] expq[$];
    logic [7:0] exp_b;
    logic [7:0] d[4];
    logic [7:0] rst_val[4] = '{8'h0c, 8'h00, 8'h60, 8'h00};
    logic [7:0] msk[4] = '{8'hff, 8'hff, 8'hff, 8'h81};
    logic [3:0] unmapped[6] = '{4'h6, 4'h7, 4'hb, 4'hd, 4'he, 4'hf};

    pllcfg_regs dut (
        .CLK(clk),
        .RESET_N(reset_n),
        .CFG_REQ(cfg_req),
        .FB_IN_TICK(fb_tick),
        .PD_EDGE(pd_edge),
        .CFG_RDATA(cfg_rdata),
        .CFG_RVALID(cfg_rvalid),
        .PLL_CFG(pll_cfg),
        .FB_DIV_OUT(fb_div_out),
        .LOCK_SAMPLE(lock_sample),
        .LOCK_IN_WINDOW(lock_in_window)
    );

    // 100 MHz system clock
    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Watchers: read data against the oldest note, divider pulse count
    // ----------------------------------------------------------------
    // Negedge sampling keeps the check clear of the launching edge
    always @(negedge clk) begin
        if (cfg_rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                `CHK("CFG_RVALID unexpected", 1'b0, cfg_rvalid)
            end else begin
                // Pop once: the macro reads its expected value twice
                exp_b = expq.pop_front();
                `CHK("CFG_RDATA", exp_b, cfg_rdata)
            end
        end
        if (fb_div_out === 1'b1) pulses++;
    end

    // ----------------------------------------------------------------
    // Bus tasks: one request per cycle, held until the next edge
    // ----------------------------------------------------------------
    task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] wd, input logic [7:0] e);
        @(posedge clk);
        cfg_req <= '{wr: w, rd: r, addr: a, wdata: wd};
        if (r) expq.push_back(e);
    endtask

    task automatic idle();
        @(posedge clk);
        cfg_req <= '0;
    endtask

    // Mid-run reset, so every scenario starts from cleared counters
    task automatic rst_dut();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
    endtask

    // Phase select that software pairs with a first divider value
    function automatic logic [2:0] ph_for(input logic [11:0] n);
        ph_for = n >= 1024 ? 3'd7 : n >= 512 ? 3'd6 : n >= 256 ? 3'd5 : n >= 128 ? 3'd4 :
            n >= 64 ? 3'd3 : n >= 32 ? 3'd2 : 3'd0;
    endfunction

    // ----------------------------------------------------------------
    // Feedback path: program ratios, feed ticks every cycle, count pulses
    // ----------------------------------------------------------------
    task automatic div_run(input logic [11:0] n1, input logic [8:0] n2, input logic casc, input logic pd,
                           input int nt, input int expn);
        rst_dut();
        acc(1'b1, 1'b0, `PLLCFG_A_FB_PH, {ph_for(n1), pd, n1[11:8]}, 8'h00);
        acc(1'b1, 1'b0, `PLLCFG_A_FB_LO, n1[7:0], 8'h00);
        acc(1'b1, 1'b0, `PLLCFG_A_S_LO, n2[7:0], 8'h00);
        acc(1'b1, 1'b0, `PLLCFG_A_S_MSB, {n2[8], 6'h00, casc}, 8'h00);
        idle();
        pulses = 0;
        repeat (nt) begin
            @(posedge clk);
            fb_tick <= 1'b1;
        end
        @(posedge clk);
        fb_tick <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("FB_DIV_OUT pulses", expn, pulses)
    endtask

    // ----------------------------------------------------------------
    // Lock window: one detector edge, a feedback pulse inside or late
    // ----------------------------------------------------------------
    task automatic lock_try(input int f, input int r, input logic hit);
        int tt;
        int ks;
        rst_dut();
        acc(1'b1, 1'b0, `PLLCFG_A_FB_PH, {f[2:0], 5'h00}, 8'h00);
        acc(1'b1, 1'b0, `PLLCFG_A_FB_LO, 8'h01, 8'h00);
        acc(1'b1, 1'b0, `PLLCFG_A_REF_PH, {r[2:0], 5'h00}, 8'h00);
        idle();
        // Ratio 1 puts the pulse two cycles after its tick
        tt = hit ? f : 2 * f + r + 5;
        ks = 0;
        @(posedge clk);
        pd_edge <= 1'b1;
        fb_tick <= (tt == 0);
        for (int k = 1; k <= 2 * f + r + 6; k++) begin
            @(posedge clk);
            pd_edge <= 1'b0;
            fb_tick <= (k == tt);
            #1;
            if (lock_sample === 1'b1 && ks == 0) ks = k;
        end
        `CHK("LOCK_SAMPLE delay", f + 2, ks)
        `CHK("LOCK_IN_WINDOW", hit, lock_in_window)
        repeat (6) @(posedge clk);
    endtask

    task automatic report_and_stop();
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run is near 9k cycles; 30k cycles leaves ample margin
    initial begin
        #300000;
        failures++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("first_fb_div_value", 12'hc00, pll_cfg.first_fb_div_value)
        `CHK("second_fb_div_value", 9'h060, pll_cfg.second_fb_div_value)
        `CHK("fb_div_phase_sel", 3'b000, pll_cfg.fb_div_phase_sel)
        `CHK("ref_div_phase_sel", 3'b000, pll_cfg.ref_div_phase_sel)
        `CHK("second_fb_div_powerdown", 1'b0, pll_cfg.second_fb_div_powerdown)
        `CHK("fb_cascade_sel", 1'b0, pll_cfg.fb_cascade_sel)
        for (int i = 0; i < 4; i++) acc(1'b0, 1'b1, i[3:0], 8'h00, rst_val[i]);
        // Random bytes, read back right behind the writes, reserved bits dropped
        for (int i = 0; i < 4; i++) begin
            d[i] = 8'($random(seed));
            acc(1'b1, 1'b0, i[3:0], d[i], 8'h00);
        end
        for (int i = 0; i < 4; i++) acc(1'b0, 1'b1, i[3:0], 8'h00, d[i] & msk[i]);
        idle();
        #1;
        `CHK("fb_div_phase_sel", d[0][7:5], pll_cfg.fb_div_phase_sel)
        `CHK("second_fb_div_powerdown", d[0][4], pll_cfg.second_fb_div_powerdown)
        `CHK("first_fb_div_value", {d[0][3:0], d[1]}, pll_cfg.first_fb_div_value)
        `CHK("second_fb_div_value", {d[3][7], d[2]}, pll_cfg.second_fb_div_value)
        `CHK("fb_cascade_sel", d[3][0], pll_cfg.fb_cascade_sel)
        // Read and write together: the read sees the old byte
        acc(1'b1, 1'b1, `PLLCFG_A_FB_LO, ~d[1], d[1]);
        acc(1'b0, 1'b1, `PLLCFG_A_FB_LO, 8'h00, ~d[1]);
        acc(1'b1, 1'b0, `PLLCFG_A_S_MSB, 8'h7e, 8'h00);
        acc(1'b0, 1'b1, `PLLCFG_A_S_MSB, 8'h00, 8'h00);
        foreach (unmapped[i]) begin
            acc(1'b1, 1'b0, unmapped[i], 8'hff, 8'h00);
            acc(1'b0, 1'b1, unmapped[i], 8'h00, 8'h00);
        end
        idle();
        rst_dut();
        @(posedge clk);
        #1;
        `CHK("first_fb_div_value", 12'hc00, pll_cfg.first_fb_div_value)
        // Divider boundaries, cascade and power-down
        div_run(12'd1, 9'd96, 1'b0, 1'b0, 10, 10);
        div_run(12'd4095, 9'd96, 1'b0, 1'b0, 4094, 0);
        div_run(12'd4095, 9'd96, 1'b0, 1'b0, 4095, 1);
        div_run(12'd3, 9'd4, 1'b1, 1'b0, 24, 2);
        div_run(12'd1, 9'd511, 1'b1, 1'b0, 511, 1);
        div_run(12'd3, 9'd4, 1'b1, 1'b1, 24, 0);
        div_run(12'd7, 9'd4, 1'b0, 1'b1, 21, 3);
        for (int f = 0; f < 8; f++) lock_try(f, $random(seed) & 7, f[0]);
        lock_try(0, 0, 1'b1);
        repeat (4) @(posedge clk);
        `CHK("pending reads", 0, expq.size())
        report_and_stop();
    end
endmodule
`default_nettype wire
